// ---- hw/timer_pwm_pkg.sv ----
package timer_pwm_pkg;
   // ***************************************************
   // Register offsets
   // ***************************************************
   localparam logic [11:0] OFS_CMP_HIGH  = 12'hF04;
   localparam logic [11:0] OFS_CMP_LOW   = 12'hF05;
   localparam logic [11:0] OFS_CTL_FIRST = 12'hF06;
   localparam logic [11:0] OFS_CTL_SECOND = 12'hF07;
   localparam logic [11:0] OFS_IRQ_STAT  = 12'hF08;
   localparam logic [11:0] OFS_IRQ_MASK  = 12'hF09;
   // ***************************************************
   // Field positions, first control register
   // ***************************************************
   localparam int MODE_HI_BIT   = 7;
   localparam int CFG_HI_BIT    = 6;
   localparam int CFG_LO_BIT    = 5;
   localparam int INSEL_BIT     = 4;
   localparam int DELAY_HI_BIT  = 3;
   localparam int DELAY_LO_BIT  = 1;
   localparam int CAPFLAG_BIT   = 0;
   // ***************************************************
   // Field positions, second control register
   // ***************************************************
   localparam int ENABLE_BIT    = 7;
   localparam int POL_BIT       = 6;
   // ***************************************************
   // Status bits
   // ***************************************************
   localparam int ST_RELOAD     = 0;
   localparam int ST_GATE       = 1;
   localparam int ST_CAPTURE    = 2;
   localparam int ST_WIDTH      = 3;
   // ***************************************************
   // Reset values
   // ***************************************************
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [2:0] RST_STAT  = 3'h0;
   // ***************************************************
   // Interrupt field codes and modes
   // ***************************************************
   localparam logic [1:0] CFG_DISABLE_OR_GATE = 2'h2;
   localparam logic [1:0] CFG_RELOAD_ONLY     = 2'h3;
   localparam logic [3:0] MODE_GATED     = 4'h6;
   localparam logic [3:0] MODE_CAPTURE   = 4'h4;
   localparam logic [3:0] MODE_CAPCMP    = 4'h7;
   localparam logic [3:0] MODE_CAPRST    = 4'hB;
   // ***************************************************
   // Dead time
   // ***************************************************
   localparam int DELAY_CNT_W = 8;
   typedef enum logic [2:0] {
      DT_IDLE = 3'b001,
      DT_WAIT = 3'b010,
      DT_ON   = 3'b100
   } dead_state_t;
endpackage

// ---- hw/dead_time_if.sv ----
`timescale 1ns/1ns
interface dead_time_if;
   logic       pwmLevel;
   logic [2:0] delayCode;
   logic       outTrue;
   logic       outComp;
   modport ctrl (output pwmLevel, output delayCode,
                 input outTrue, input outComp);
   modport gen  (input pwmLevel, input delayCode,
                 output outTrue, output outComp);
endinterface

// ---- hw/dead_time_gen.sv ----
`timescale 1ns/1ns
module dead_time_gen (
   input  wire logic mclk,
   input  wire logic resetn,
   dead_time_if.gen  dt
);
   // ***************************************************
   // One delayed channel per phase
   // ***************************************************
   logic [1:0] chanOut;
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : chan
         timer_pwm_pkg::dead_state_t state_reg;
         logic [timer_pwm_pkg::DELAY_CNT_W-1:0] cnt_reg;
         logic [timer_pwm_pkg::DELAY_CNT_W-1:0] target;
         logic want;
         // Zero code lands in DT_ON the very next cycle
         assign target = (dt.delayCode == 3'h0) ? 8'h00 :
            8'(8'h01 << dt.delayCode);
         assign want = (g == 0) ? dt.pwmLevel : ~dt.pwmLevel;
         always_ff @(posedge mclk) begin
            if (!resetn) begin
               state_reg <= timer_pwm_pkg::DT_IDLE;
               cnt_reg   <= 8'h00;
            end else begin
               case (state_reg)
                  timer_pwm_pkg::DT_IDLE: begin
                     cnt_reg <= 8'h00;
                     if (want) begin
                        state_reg <= (target == 8'h00) ?
                           timer_pwm_pkg::DT_ON : timer_pwm_pkg::DT_WAIT;
                     end
                  end
                  timer_pwm_pkg::DT_WAIT: begin
                     if (!want) begin
                        state_reg <= timer_pwm_pkg::DT_IDLE;
                     end else if (cnt_reg == target - 8'h01) begin
                        state_reg <= timer_pwm_pkg::DT_ON;
                     end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                     end
                  end
                  timer_pwm_pkg::DT_ON: begin
                     // Deassert at once; only assertion is delayed
                     if (!want) begin
                        state_reg <= timer_pwm_pkg::DT_IDLE;
                     end
                  end
                  default: state_reg <= timer_pwm_pkg::DT_IDLE;
               endcase
            end
         end
         assign chanOut[g] = (state_reg == timer_pwm_pkg::DT_ON);
      end
   endgenerate
   assign dt.outTrue = chanOut[0];
   assign dt.outComp = chanOut[1];
endmodule

// ---- hw/irq_source_select.sv ----
`timescale 1ns/1ns
module irq_source_select (
   input  wire logic [3:0] mode,
   input  wire logic [1:0] cfg,
   input  wire logic       reloadEvt,
   input  wire logic       gateEvt,
   input  wire logic       captureEvt,
   output logic            reloadIrq,
   output logic            gateIrq,
   output logic            captureIrq
);
   logic isGated;
   logic isCapture;
   assign isGated   = (mode == timer_pwm_pkg::MODE_GATED);
   assign isCapture = (mode == timer_pwm_pkg::MODE_CAPTURE) ||
                      (mode == timer_pwm_pkg::MODE_CAPCMP) ||
                      (mode == timer_pwm_pkg::MODE_CAPRST);
   always_comb begin
      reloadIrq  = 1'b0;
      gateIrq    = 1'b0;
      captureIrq = 1'b0;
      if (isGated) begin
         reloadIrq = reloadEvt &
            (cfg != timer_pwm_pkg::CFG_DISABLE_OR_GATE);
         gateIrq = gateEvt &
            (cfg != timer_pwm_pkg::CFG_RELOAD_ONLY);
      end else if (isCapture) begin
         reloadIrq = reloadEvt &
            (cfg != timer_pwm_pkg::CFG_DISABLE_OR_GATE);
         captureIrq = captureEvt &
            (cfg != timer_pwm_pkg::CFG_RELOAD_ONLY);
      end else begin
         reloadIrq = reloadEvt &
            (cfg != timer_pwm_pkg::CFG_DISABLE_OR_GATE);
      end
   end
endmodule

// ---- hw/timer_pwm_cfg.sv ----
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
// Functional notes
// - Two compare byte registers, reset zero
// - First control bit 7 is mode MSB
// - Plain modes: reload interrupts unless field 10
// - Gated mode: reload and/or inactive gate edge
// - Capture modes: reload and/or capture events
// - Input select: pin or comparator output
// - Dead time 0 or 2^code cycles
// - Read-only flag: last interrupt was capture
// - Disabled timer output equals polarity bit
module timer_pwm_cfg (
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic [11:0] regAddr,
   input  wire logic [7:0]  regWdata,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic      [7:0]  regRdata,
   input  wire logic        timerInPin,
   input  wire logic        comparatorOut,
   input  wire logic        reloadEvt,
   input  wire logic        gateEvt,
   input  wire logic        captureEvt,
   input  wire logic        pwmMatchLevel,
   output logic      [15:0] compareValue,
   output logic      [3:0]  operatingModeCode,
   output logic      [1:0]  interruptSourceConfig,
   output logic             timerInput,
   output logic             timerOut,
   output logic             timerOutComp,
   output logic             timerIrq,
   output logic             irqOut
);
   // ***************************************************
   // Registers
   // ***************************************************
   logic [7:0] cmpHigh_reg;
   logic [7:0] cmpLow_reg;
   logic       modeHi_reg;
   logic [1:0] cfg_reg;
   logic       inSel_reg;
   logic [2:0] delay_reg;
   logic       capFlag_reg;
   logic [2:0] modeLo_reg;
   logic       enable_reg;
   logic       pol_reg;
   logic [2:0] ctl2Rest_reg;
   logic [timer_pwm_pkg::ST_WIDTH-1:0] stat_reg;
   logic [timer_pwm_pkg::ST_WIDTH-1:0] mask_reg;
   logic [timer_pwm_pkg::ST_WIDTH-1:0] stat_next;
   logic [7:0] rdata_next;
   logic       pinMeta_reg;
   logic       pinSync_reg;
   logic       cmpMeta_reg;
   logic       cmpSync_reg;
   logic       reloadIrq;
   logic       gateIrq;
   logic       captureIrq;
   logic       outTrue_reg;
   logic       outComp_reg;
   logic       timerIrq_reg;
   dead_time_if dtBus ();

   // ***************************************************
   // Register writes
   // ***************************************************
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cmpHigh_reg <= timer_pwm_pkg::RST_BYTE;
         cmpLow_reg  <= timer_pwm_pkg::RST_BYTE;
      end else if (regWrite) begin
         if (regAddr == timer_pwm_pkg::OFS_CMP_HIGH) begin
            cmpHigh_reg <= regWdata;
         end
         if (regAddr == timer_pwm_pkg::OFS_CMP_LOW) begin
            cmpLow_reg <= regWdata;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         modeHi_reg <= 1'b0;
         cfg_reg    <= 2'h0;
         inSel_reg  <= 1'b0;
         delay_reg  <= 3'h0;
      end else if (regWrite &&
                   regAddr == timer_pwm_pkg::OFS_CTL_FIRST) begin
         // Capture flag bit is read-only, write ignored
         modeHi_reg <= regWdata[timer_pwm_pkg::MODE_HI_BIT];
         cfg_reg    <= regWdata[timer_pwm_pkg::CFG_HI_BIT:
                                timer_pwm_pkg::CFG_LO_BIT];
         inSel_reg  <= regWdata[timer_pwm_pkg::INSEL_BIT];
         delay_reg  <= regWdata[timer_pwm_pkg::DELAY_HI_BIT:
                                timer_pwm_pkg::DELAY_LO_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         enable_reg   <= 1'b0;
         pol_reg      <= 1'b0;
         ctl2Rest_reg <= 3'h0;
         modeLo_reg   <= 3'h0;
      end else if (regWrite &&
                   regAddr == timer_pwm_pkg::OFS_CTL_SECOND) begin
         enable_reg   <= regWdata[timer_pwm_pkg::ENABLE_BIT];
         pol_reg      <= regWdata[timer_pwm_pkg::POL_BIT];
         ctl2Rest_reg <= regWdata[5:3];
         modeLo_reg   <= regWdata[2:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         mask_reg <= timer_pwm_pkg::RST_STAT;
      end else if (regWrite &&
                   regAddr == timer_pwm_pkg::OFS_IRQ_MASK) begin
         mask_reg <= regWdata[timer_pwm_pkg::ST_WIDTH-1:0];
      end
   end

   // ***************************************************
   // Mode, compare and input select
   // ***************************************************
   assign operatingModeCode = {modeHi_reg, modeLo_reg};
   assign interruptSourceConfig = cfg_reg;
   assign compareValue = {cmpHigh_reg, cmpLow_reg};

   // Both sources are asynchronous to mclk
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         pinMeta_reg <= 1'b0;
         pinSync_reg <= 1'b0;
         cmpMeta_reg <= 1'b0;
         cmpSync_reg <= 1'b0;
      end else begin
         pinMeta_reg <= timerInPin;
         pinSync_reg <= pinMeta_reg;
         cmpMeta_reg <= comparatorOut;
         cmpSync_reg <= cmpMeta_reg;
      end
   end
   assign timerInput = inSel_reg ? cmpSync_reg : pinSync_reg;

   // ***************************************************
   // Interrupt sources
   // ***************************************************
   irq_source_select irqSel (
      .mode       (operatingModeCode),
      .cfg        (cfg_reg),
      .reloadEvt  (reloadEvt),
      .gateEvt    (gateEvt),
      .captureEvt (captureEvt),
      .reloadIrq  (reloadIrq),
      .gateIrq    (gateIrq),
      .captureIrq (captureIrq)
   );

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         timerIrq_reg <= 1'b0;
      end else begin
         timerIrq_reg <= reloadIrq | gateIrq | captureIrq;
      end
   end
   assign timerIrq = timerIrq_reg;

   // Flag follows the cause of the latest interrupt only
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         capFlag_reg <= 1'b0;
      end else if (captureIrq) begin
         capFlag_reg <= 1'b1;
      end else if (reloadIrq | gateIrq) begin
         capFlag_reg <= 1'b0;
      end
   end

   // Set wins over a write-one clear in the same cycle
   always_comb begin
      stat_next = stat_reg;
      if (regWrite && regAddr == timer_pwm_pkg::OFS_IRQ_STAT) begin
         stat_next = stat_reg & ~regWdata[timer_pwm_pkg::ST_WIDTH-1:0];
      end
      stat_next[timer_pwm_pkg::ST_RELOAD] =
         stat_next[timer_pwm_pkg::ST_RELOAD] | reloadIrq;
      stat_next[timer_pwm_pkg::ST_GATE] =
         stat_next[timer_pwm_pkg::ST_GATE] | gateIrq;
      stat_next[timer_pwm_pkg::ST_CAPTURE] =
         stat_next[timer_pwm_pkg::ST_CAPTURE] | captureIrq;
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         stat_reg <= timer_pwm_pkg::RST_STAT;
      end else begin
         stat_reg <= stat_next;
      end
   end
   assign irqOut = |(stat_reg & mask_reg);

   // ***************************************************
   // Dead time and output
   // ***************************************************
   assign dtBus.pwmLevel  = pwmMatchLevel & enable_reg;
   assign dtBus.delayCode = delay_reg;

   dead_time_gen deadTime (
      .mclk   (mclk),
      .resetn (resetn),
      .dt     (dtBus.gen)
   );

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         outTrue_reg <= 1'b0;
         outComp_reg <= 1'b0;
      end else if (!enable_reg) begin
         outTrue_reg <= pol_reg;
         outComp_reg <= ~pol_reg;
      end else begin
         outTrue_reg <= dtBus.outTrue ^ pol_reg;
         // Same sense as the true phase, so both rest at pol_reg during dead time
         outComp_reg <= dtBus.outComp ^ pol_reg;
      end
   end
   assign timerOut     = outTrue_reg;
   assign timerOutComp = outComp_reg;

   // ***************************************************
   // Register reads
   // ***************************************************
   always_comb begin
      rdata_next = 8'h00;
      case (regAddr)
         timer_pwm_pkg::OFS_CMP_HIGH:  rdata_next = cmpHigh_reg;
         timer_pwm_pkg::OFS_CMP_LOW:   rdata_next = cmpLow_reg;
         timer_pwm_pkg::OFS_CTL_FIRST: rdata_next =
            {modeHi_reg, cfg_reg, inSel_reg, delay_reg, capFlag_reg};
         timer_pwm_pkg::OFS_CTL_SECOND: rdata_next =
            {enable_reg, pol_reg, ctl2Rest_reg, modeLo_reg};
         timer_pwm_pkg::OFS_IRQ_STAT:  rdata_next = {5'h00, stat_reg};
         timer_pwm_pkg::OFS_IRQ_MASK:  rdata_next = {5'h00, mask_reg};
         default:                      rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         regRdata <= rdata_next;
      end else begin
         regRdata <= 8'h00;
      end
   end
endmodule

// ---- test/timer_core_model.sv ----
`timescale 1ns/1ns
module timer_core_model (
   input  wire logic mclk,
   output logic      reloadEvt,
   output logic      gateEvt,
   output logic      captureEvt,
   output logic      pwmMatchLevel,
   output logic      timerInPin,
   output logic      comparatorOut
);
   initial begin
      {reloadEvt, gateEvt, captureEvt} = 3'h0;
      {pwmMatchLevel, timerInPin, comparatorOut} = 3'h0;
   end
   // One-cycle event pulse, 0 reload, 1 gate, 2 capture
   task pulse(input int k);
      @(posedge mclk);
      reloadEvt <= (k == 0);
      gateEvt <= (k == 1);
      captureEvt <= (k == 2);
      @(posedge mclk);
      {reloadEvt, gateEvt, captureEvt} <= 3'h0;
   endtask
   task setLevel(input logic v);
      @(posedge mclk);
      pwmMatchLevel <= v;
   endtask
   // Opposite levels so a wrong select shows
   task setPins(input logic p, input logic c);
      @(posedge mclk);
      timerInPin <= p;
      comparatorOut <= c;
   endtask
endmodule

// ---- test/timer_pwm_cfg_sva.sv ----
`timescale 1ns/1ns
module timer_pwm_cfg_sva (
   input wire logic        mclk,
   input wire logic        resetn,
   input wire logic [11:0] regAddr,
   input wire logic [7:0]  regWdata,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [7:0]  regRdata,
   input wire logic        reloadEvt,
   input wire logic        gateEvt,
   input wire logic        captureEvt,
   input wire logic [15:0] compareValue,
   input wire logic [3:0]  operatingModeCode,
   input wire logic [1:0]  interruptSourceConfig,
   input wire logic        timerOut,
   input wire logic        timerOutComp,
   input wire logic        timerIrq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   logic polSeen;
   logic polUsed;
   // Outputs take a new polarity one edge after the register
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         polSeen <= 1'b0;
         polUsed <= 1'b0;
      end else begin
         if (regWrite && regAddr == timer_pwm_pkg::OFS_CTL_SECOND) begin
            polSeen <= regWdata[timer_pwm_pkg::POL_BIT];
         end
         polUsed <= polSeen;
      end
   end
   sequence s_wr_first;
      regWrite && regAddr == timer_pwm_pkg::OFS_CTL_FIRST;
   endsequence
   sequence s_wr_high;
      regWrite && regAddr == timer_pwm_pkg::OFS_CMP_HIGH;
   endsequence
   sequence s_wr_low;
      regWrite && regAddr == timer_pwm_pkg::OFS_CMP_LOW;
   endsequence
   a_read_idle_zero: assert property (!regRead |=> regRdata == 8'h00)
      else $error("read data not zero when idle");
   a_cmp_high_wr: assert property (s_wr_high |=>
      compareValue[15:8] == $past(regWdata)) else $error("high byte");
   a_cmp_low_wr: assert property (s_wr_low |=>
      compareValue[7:0] == $past(regWdata)) else $error("low byte");
   a_cmp_hold: assert property (!regWrite |=> $stable(compareValue))
      else $error("compare value moved");
   a_mode_msb: assert property (s_wr_first |=>
      operatingModeCode[3] == $past(regWdata[7])) else $error("mode msb");
   a_cfg_field: assert property (s_wr_first |=>
      interruptSourceConfig == $past(regWdata[6:5])) else $error("cfg");
   a_plain_reload: assert property (reloadEvt && operatingModeCode == 4'h1
      && interruptSourceConfig != 2'h2 |=> timerIrq)
      else $error("missing reload irq");
   a_plain_mute: assert property (reloadEvt && !gateEvt && !captureEvt
      && operatingModeCode == 4'h1 && interruptSourceConfig == 2'h2
      |=> !timerIrq) else $error("irq while disabled");
   a_capture_mute: assert property (captureEvt && !reloadEvt && !gateEvt
      && operatingModeCode == timer_pwm_pkg::MODE_CAPTURE
      && interruptSourceConfig == 2'h3 |=> !timerIrq)
      else $error("capture irq in reload only");
   a_dead_gap: assert property (!((timerOut ^ polUsed) &&
      (timerOutComp ^ polUsed)))
      else $error("outputs overlap");
endmodule
bind timer_pwm_cfg timer_pwm_cfg_sva u_sva (
   .mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
   .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
   .reloadEvt(reloadEvt), .gateEvt(gateEvt), .captureEvt(captureEvt),
   .compareValue(compareValue), .operatingModeCode(operatingModeCode),
   .interruptSourceConfig(interruptSourceConfig), .timerOut(timerOut),
   .timerOutComp(timerOutComp), .timerIrq(timerIrq));

// ---- test/timer_pwm_cfg_test.sv ----
`timescale 1ns/1ns
module timer_pwm_cfg_test;
   logic        mclk, resetn, regWrite, regRead;
   logic [11:0] regAddr;
   logic [7:0]  regWdata, regRdata, d;
   logic        reloadEvt, gateEvt, captureEvt, pwmMatchLevel;
   logic        timerInPin, comparatorOut, timerInput, timerOut;
   logic        timerOutComp, timerIrq, irqOut;
   logic [15:0] compareValue;
   logic [3:0]  operatingModeCode;
   logic [1:0]  interruptSourceConfig;
   int          bad_count, check_count, cycles;
   timer_core_model u_core (.mclk(mclk), .reloadEvt(reloadEvt),
      .gateEvt(gateEvt), .captureEvt(captureEvt),
      .pwmMatchLevel(pwmMatchLevel), .timerInPin(timerInPin),
      .comparatorOut(comparatorOut));
   timer_pwm_cfg u_dut (.mclk(mclk), .resetn(resetn), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
      .regRdata(regRdata), .timerInPin(timerInPin),
      .comparatorOut(comparatorOut), .reloadEvt(reloadEvt),
      .gateEvt(gateEvt), .captureEvt(captureEvt),
      .pwmMatchLevel(pwmMatchLevel), .compareValue(compareValue),
      .operatingModeCode(operatingModeCode),
      .interruptSourceConfig(interruptSourceConfig),
      .timerInput(timerInput), .timerOut(timerOut),
      .timerOutComp(timerOutComp), .timerIrq(timerIrq), .irqOut(irqOut));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // Generous ceiling: dead time sweep dominates
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         summarize();
      end
   end
   task summarize;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge mclk);
      regAddr <= a;
      regWdata <= v;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask
   task rd(input logic [11:0] a);
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      #1 d = regRdata;
   endtask
   task t_regs;
      rd(12'hF04); chk(d, 8'h00);
      rd(12'hF05); chk(d, 8'h00);
      rd(12'h0FF); chk(d, 8'h00);
      wr(12'hF04, 8'hA5);
      wr(12'hF05, 8'h3C);
      rd(12'hF04); chk(d, 8'hA5);
      chk(compareValue, 16'hA53C);
      wr(12'hF06, 8'hFF);
      #1 chk(interruptSourceConfig, 2'h3);
      rd(12'hF06); chk(d, 8'hFE);
      wr(12'hF07, 8'h05);
      #1 chk(operatingModeCode, 4'hD);
   endtask
   // Columns: mode, field, event kind, interrupt expected
   logic [8:0] tbl [17] = '{{4'h1,2'h0,2'h0,1'b1}, {4'h1,2'h1,2'h0,1'b1},
      {4'h1,2'h2,2'h0,1'b0}, {4'h1,2'h3,2'h0,1'b1}, {4'h6,2'h0,2'h0,1'b1},
      {4'h6,2'h0,2'h1,1'b1}, {4'h6,2'h2,2'h0,1'b0}, {4'h6,2'h2,2'h1,1'b1},
      {4'h6,2'h3,2'h1,1'b0}, {4'h6,2'h3,2'h0,1'b1}, {4'h4,2'h0,2'h2,1'b1},
      {4'h4,2'h2,2'h2,1'b1}, {4'h4,2'h2,2'h0,1'b0}, {4'h4,2'h3,2'h2,1'b0},
      {4'h7,2'h1,2'h2,1'b1}, {4'hB,2'h3,2'h0,1'b1}, {4'hB,2'h0,2'h0,1'b1}};
   task t_irq_table;
      for (int i = 0; i < 17; i++) begin
         wr(12'hF06, {tbl[i][8], tbl[i][4:3], 5'h00});
         wr(12'hF07, {5'h00, tbl[i][7:5]});
         u_core.pulse(int'(tbl[i][2:1]));
         #1 chk(timerIrq, tbl[i][0]);
         rd(12'hF06);
         if (tbl[i][0]) chk(d[0], tbl[i][2:1] == 2'h2);
      end
   endtask
   task t_irq_mask;
      wr(12'hF08, 8'h07);
      wr(12'hF06, 8'h00);
      wr(12'hF07, 8'h01);
      wr(12'hF09, 8'h00);
      u_core.pulse(0);
      #1 chk(irqOut, 1'b0);
      wr(12'hF09, 8'h01);
      #1 chk(irqOut, 1'b1);
      rd(12'hF08); chk(d, 8'h01);
      wr(12'hF08, 8'h01);
      #1 chk(irqOut, 1'b0);
      // Event and clear in one cycle: the event must win
      fork
         u_core.pulse(0);
         wr(12'hF08, 8'h01);
      join
      #1 chk(irqOut, 1'b1);
   endtask
   task t_reset;
      wr(12'hF05, 8'h5A);
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      rd(12'hF05); chk(d, 8'h00);
      chk(compareValue, 16'h0000);
   endtask
   task t_input_sel;
      u_core.setPins(1'b1, 1'b0);
      wr(12'hF06, 8'h00);
      repeat (3) @(posedge mclk);
      #1 chk(timerInput, 1'b1);
      wr(12'hF06, 8'h10);
      #1 chk(timerInput, 1'b0);
   endtask
   task t_dead;
      int n;
      int e;
      wr(12'hF07, 8'h80);
      for (int c = 0; c < 8; c++) begin
         e = 2 + ((c == 0) ? 0 : (1 << c));
         wr(12'hF06, 8'(c * 2));
         u_core.setLevel(1'b1);
         n = 0;
         while (timerOut !== 1'b1 && n < 300) begin
            @(posedge mclk);
            #1 n++;
         end
         chk(n, e);
         chk(timerOutComp, 1'b0);
         u_core.setLevel(1'b0);
         n = 0;
         while (timerOutComp !== 1'b1 && n < 300) begin
            @(posedge mclk);
            #1 n++;
         end
         chk(n, e);
      end
      wr(12'hF07, 8'h40);
      repeat (2) @(posedge mclk);
      #1 chk(timerOut, 1'b1);
      chk(timerOutComp, 1'b0);
   endtask
   initial begin
      {resetn, regWrite, regRead, regAddr, regWdata} = '0;
      bad_count = 0;
      check_count = 0;
      cycles = 0;
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      t_regs();
      t_irq_table();
      t_irq_mask();
      t_input_sel();
      t_dead();
      t_reset();
      summarize();
   end
endmodule
